// File: hw/adaptor_bus_hold.sv
// Purpose: Adaptor end: requests the bus and runs DMA write bursts
// Assumes: Glue logic on the far side forms grant from request
// Notes:   A grant seen while requesting is taken as ownership
`timescale 1ns/10ps
module adaptor_bus_hold #(
  parameter int AW = bus_hold_pkg::ADDR_W,
  parameter int DW = bus_hold_pkg::DATA_W,
  parameter int LW = bus_hold_pkg::LEN_W
) (
  input  wire logic          clk_sys_i,
  input  wire logic          srst_i,
  bus_hold_if.adaptor        link,
  input  wire logic          start_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [LW-1:0] len_i,
  input  wire logic [DW-1:0] data_i,
  output logic               ready_o,
  output logic               data_take_o,
  output logic               done_o,
  output logic               aborted_o
);

  bus_hold_pkg::dev_state_t state_reg;
  logic                     req_n_reg;
  logic                     busy_n_reg;
  logic                     we_reg;
  logic [AW-1:0]            addr_reg;
  logic [DW-1:0]            wdata_reg;
  logic [AW-1:0]            cur_reg;
  logic [LW-1:0]            left_reg;
  logic [bus_hold_pkg::GAP_W-1:0] gap_reg;
  logic                     ready_reg;
  logic                     take_reg;
  logic                     done_reg;
  logic                     abort_reg;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.hold_request_n = req_n_reg;
  assign link.busy_n         = busy_n_reg;
  assign link.dma_we         = we_reg;
  assign link.dma_addr       = addr_reg;
  assign link.dma_wdata      = wdata_reg;
  assign ready_o             = ready_reg;
  assign data_take_o         = take_reg;
  assign done_o              = done_reg;
  assign aborted_o           = abort_reg;

  // ----------------------------------------------------------------
  // Request, ownership and burst sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    take_reg  <= 1'b0;
    done_reg  <= 1'b0;
    abort_reg <= 1'b0;
    we_reg    <= 1'b0;
    if (srst_i) begin
      state_reg  <= bus_hold_pkg::DEV_IDLE;
      req_n_reg  <= 1'b1;
      busy_n_reg <= 1'b1;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      cur_reg    <= '0;
      left_reg   <= '0;
      gap_reg    <= '0;
      ready_reg  <= 1'b1;
    end else begin
      unique case (state_reg)
        bus_hold_pkg::DEV_IDLE: begin
          // Zero-length bursts never disturb the bus
          if (start_i && (len_i != '0)) begin
            cur_reg   <= addr_i;
            left_reg  <= len_i;
            req_n_reg <= 1'b0; // see R1
            ready_reg <= 1'b0;
            state_reg <= bus_hold_pkg::DEV_REQ;
          end
        end
        bus_hold_pkg::DEV_REQ: begin
          if (!link.hold_grant_n) begin // see R8
            busy_n_reg <= 1'b0; // see R2
            state_reg  <= bus_hold_pkg::DEV_OWN;
          end
        end
        bus_hold_pkg::DEV_OWN: begin
          if (left_reg == '0 || link.hold_grant_n) begin
            busy_n_reg <= 1'b1; // see R2
            req_n_reg  <= 1'b1;
            done_reg   <= (left_reg == '0);
            abort_reg  <= (left_reg != '0);
            gap_reg    <= bus_hold_pkg::GAP_W'(bus_hold_pkg::GAP_CYCLES);
            state_reg  <= bus_hold_pkg::DEV_GAP;
          end else begin
            // One write per clock, no wait cycles
            we_reg    <= 1'b1; // see R10
            addr_reg  <= cur_reg;
            wdata_reg <= data_i;
            take_reg  <= 1'b1;
            cur_reg   <= cur_reg + AW'(1);
            left_reg  <= left_reg - LW'(1);
          end
        end
        bus_hold_pkg::DEV_GAP: begin
          // Request stays off long enough for the grant to clear
          if (gap_reg == bus_hold_pkg::GAP_W'(1)) begin
            ready_reg <= 1'b1;
            state_reg <= bus_hold_pkg::DEV_IDLE;
          end
          gap_reg <= gap_reg - bus_hold_pkg::GAP_W'(1);
        end
      endcase
    end
  end

endmodule

// File: hw/bus_hold_glue.sv
// Purpose: Glue between the processor's hold port and the adaptor
// Assumes: Exactly one processor and one adaptor share the bus
// Notes:   Grant is gated by the registered adaptor request
`timescale 1ns/10ps
// Operation
// R1: Hold request means wish, not ownership
// R2: Busy low marks actual adaptor bus ownership
// R3: Processor request is request OR busy
// R4: Adaptor grant is processor acknowledge AND request
// R5: Grant uses clock-registered adaptor request
// R6: Exactly two masters: processor and adaptor
// R7: Never wire request and acknowledge straight through
// R8: Adaptor takes any asserted grant as ownership
// R9: Processor withdraws acknowledge; adaptor must notice
// R10: Adaptor DMA cycles insert no wait cycles
module bus_hold_glue #(
  parameter int AW          = bus_hold_pkg::ADDR_W,
  parameter int DW          = bus_hold_pkg::DATA_W,
  parameter int CW          = bus_hold_pkg::CNT_W,
  parameter int NUM_MASTERS = bus_hold_pkg::NUM_MASTERS
) (
  input  wire logic          clk_sys_i,
  input  wire logic          srst_i,
  bus_hold_if.glue           link,
  input  wire logic          cpu_ack_n_i,
  input  wire logic          conflict_clr_i,
  output logic               cpu_req_n_o,
  output logic               mem_we_o,
  output logic [AW-1:0]      mem_addr_o,
  output logic [DW-1:0]      mem_wdata_o,
  output bus_hold_pkg::owner_t owner_o,
  output logic               revoke_o,
  output logic               conflict_o,
  output logic [CW-1:0]      grant_count_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The gating only separates two parties; a third has no path
  if (NUM_MASTERS != 2) begin : g_bad_masters
    $error("bus_hold_glue serves exactly two bus masters"); // see R6
  end
  if (CW < 1) begin : g_bad_cw
    $error("bus_hold_glue needs a grant counter of one bit or more");
  end
  if (AW < 1) begin : g_bad_aw
    $error("bus_hold_glue needs an address of one bit or more");
  end
  if (DW < 1) begin : g_bad_dw
    $error("bus_hold_glue needs a data word of one bit or more");
  end

  logic                 req_sync_reg;
  logic                 cpu_req_n_reg;
  logic                 grant_n_reg;
  logic                 ack_n_d_reg;
  logic                 revoke_reg;
  logic                 conflict_reg;
  logic                 mem_we_reg;
  logic [AW-1:0]        mem_addr_reg;
  logic [DW-1:0]        mem_wdata_reg;
  bus_hold_pkg::owner_t owner_reg;
  logic [CW-1:0]        grant_cnt_reg;
  logic                 grant_n_next;
  logic                 conflict_set;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.hold_grant_n = grant_n_reg;
  assign cpu_req_n_o       = cpu_req_n_reg;
  assign mem_we_o          = mem_we_reg;
  assign mem_addr_o        = mem_addr_reg;
  assign mem_wdata_o       = mem_wdata_reg;
  assign owner_o           = owner_reg;
  assign revoke_o          = revoke_reg;
  assign conflict_o        = conflict_reg;
  assign grant_count_o     = grant_cnt_reg;

  // ----------------------------------------------------------------
  // Gating terms
  // ----------------------------------------------------------------
  // Active low: AND of lows is OR of asserted, OR of lows is AND
  function automatic logic or_low(input logic a_n, input logic b_n);
    return a_n & b_n;
  endfunction

  function automatic logic and_low(input logic a_n, input logic b_n);
    return a_n | b_n;
  endfunction

  always_comb begin
    grant_n_next = and_low(cpu_ack_n_i, req_sync_reg); // see R4
    conflict_set = ~link.busy_n & cpu_ack_n_i;
  end

  // ----------------------------------------------------------------
  // Request towards the processor
  // ----------------------------------------------------------------
  // Busy keeps the processor off even once the request has dropped
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cpu_req_n_reg <= 1'b1;
    end else begin
      cpu_req_n_reg <= or_low(link.hold_request_n, link.busy_n); // see R3
    end
  end

  // ----------------------------------------------------------------
  // Grant towards the adaptor
  // ----------------------------------------------------------------
  // A straight acknowledge would stay low across a one-clock gap in
  // the request and hand the adaptor a stale grant
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      req_sync_reg <= 1'b1;
    end else begin
      req_sync_reg <= link.hold_request_n; // see R5
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      grant_n_reg <= 1'b1;
    end else begin
      grant_n_reg <= grant_n_next; // see R7
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge withdrawal
  // ----------------------------------------------------------------
  // Rising acknowledge clears the grant at the next edge as well
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ack_n_d_reg <= 1'b1;
      revoke_reg  <= 1'b0;
    end else begin
      ack_n_d_reg <= cpu_ack_n_i;
      revoke_reg  <= cpu_ack_n_i & ~ack_n_d_reg & ~link.busy_n; // see R9
    end
  end

  // ----------------------------------------------------------------
  // Ownership view
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      owner_reg <= bus_hold_pkg::OWNER_CPU;
    end else if (cpu_ack_n_i) begin
      owner_reg <= bus_hold_pkg::OWNER_CPU;
    end else if (!link.busy_n) begin
      owner_reg <= bus_hold_pkg::OWNER_ADAPTOR; // see R2
    end else begin
      owner_reg <= bus_hold_pkg::OWNER_FREE;
    end
  end

  // ----------------------------------------------------------------
  // Overlap detection
  // ----------------------------------------------------------------
  // Sticky; a new overlap in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      conflict_reg <= 1'b0;
    end else if (conflict_set) begin
      conflict_reg <= 1'b1;
    end else if (conflict_clr_i) begin
      conflict_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Grant counter
  // ----------------------------------------------------------------
  // Counts grant assertions; wraps silently
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      grant_cnt_reg <= '0;
    end else if (grant_n_reg && !grant_n_next) begin
      grant_cnt_reg <= grant_cnt_reg + CW'(1);
    end
  end

  // ----------------------------------------------------------------
  // DMA cycles towards memory
  // ----------------------------------------------------------------
  // No ready path back: the adaptor never waits
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mem_we_reg <= 1'b0;
    end else begin
      mem_we_reg <= link.dma_we & ~link.busy_n; // see R10
    end
  end

  // Address and data move only with a write and hold in between
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mem_addr_reg  <= '0;
      mem_wdata_reg <= '0;
    end else if (link.dma_we) begin
      mem_addr_reg  <= link.dma_addr;
      mem_wdata_reg <= link.dma_wdata;
    end
  end

endmodule

// File: hw/bus_hold_if.sv
// Purpose: Wires between the adaptor's hold port and the glue logic
// Assumes: All signals synchronous to clk_sys_i
// Notes:   Hold signals are active low; DMA bus is active high
`timescale 1ns/10ps
interface bus_hold_if #(
  parameter int AW = bus_hold_pkg::ADDR_W,
  parameter int DW = bus_hold_pkg::DATA_W
);
  logic          hold_request_n;
  logic          busy_n;
  logic          hold_grant_n;
  logic          dma_we;
  logic [AW-1:0] dma_addr;
  logic [DW-1:0] dma_wdata;

  modport adaptor (
    output hold_request_n,
    output busy_n,
    output dma_we,
    output dma_addr,
    output dma_wdata,
    input  hold_grant_n
  );

  modport glue (
    input  hold_request_n,
    input  busy_n,
    input  dma_we,
    input  dma_addr,
    input  dma_wdata,
    output hold_grant_n
  );
endinterface

// File: hw/bus_hold_pkg.sv
// Purpose: Shared constants and types for the bus hold link
// Assumes: One clock, synchronous active-high reset
// Notes:   Both ends and the interface take widths from here
package bus_hold_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 16;
  localparam int LEN_W       = 8;
  localparam int CNT_W       = 16;

  // ----------------------------------------------------------------
  // Arbitration constants
  // ----------------------------------------------------------------
  localparam int NUM_MASTERS = 2;
  // Idle cycles after releasing, longer than the glue's grant path
  localparam int GAP_CYCLES  = 3;
  localparam int GAP_W       = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_REQ,
    DEV_OWN,
    DEV_GAP
  } dev_state_t;

  typedef enum logic [1:0] {
    OWNER_CPU,
    OWNER_FREE,
    OWNER_ADAPTOR
  } owner_t;

endpackage

// File: tb/bus_hold_chk.sv
// Purpose: Assertions on the hold link and processor handshake
// Assumes: One clock, synchronous active-high reset
// Notes:   Hold signals are active low
`timescale 1ns/10ps
module bus_hold_chk #(
  parameter int AW = 16
) (
  input wire logic          clk_sys_i,
  input wire logic          srst_i,
  input wire logic          hold_request_n,
  input wire logic          busy_n,
  input wire logic          hold_grant_n,
  input wire logic          dma_we,
  input wire logic [AW-1:0] dma_addr,
  input wire logic          cpu_ack_n_i,
  input wire logic          cpu_req_n_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  property p_req_or;
    1 |=> cpu_req_n_o == $past(hold_request_n & busy_n);
  endproperty
  a_req_or: assert property (p_req_or)
    else $error("processor request is not request or busy");

  property p_grant_and;
    1 |=> hold_grant_n == ($past(cpu_ack_n_i) | $past(hold_request_n, 2));
  endproperty
  a_grant_and: assert property (p_grant_and)
    else $error("grant is not ack and registered request");

  property p_grant_drop;
    $rose(hold_request_n) |=> ##1 hold_grant_n;
  endproperty
  a_grant_drop: assert property (p_grant_drop)
    else $error("grant outlives a dropped request");

  property p_req_first;
    $fell(hold_request_n) |-> busy_n;
  endproperty
  a_req_first: assert property (p_req_first)
    else $error("busy came with the request");

  property p_busy_granted;
    $fell(busy_n) |-> $past(!hold_grant_n) && !hold_request_n;
  endproperty
  a_busy_granted: assert property (p_busy_granted)
    else $error("busy without grant");

  property p_no_wait;
    $fell(busy_n) && !hold_grant_n |=> dma_we;
  endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("first write delayed");

  property p_addr_step;
    dma_we && $past(dma_we) |-> dma_addr == $past(dma_addr) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("write address did not step");

  property p_we_owned;
    dma_we |-> !busy_n;
  endproperty
  a_we_owned: assert property (p_we_owned)
    else $error("write while not owning");

  property p_revoke;
    $rose(hold_grant_n) && !busy_n |=> busy_n && hold_request_n;
  endproperty
  a_revoke: assert property (p_revoke)
    else $error("withdrawn grant not obeyed");
endmodule

// File: tb/test_dma_bus_hold_arbitration_glue.sv
// Purpose: Bursts across the adaptor and glue with a processor model
// Assumes: Processor acks half a cycle after request, at the falling edge, unless held back
// Notes:   Data and address of each forwarded write are checked
`timescale 1ns/10ps
module test_dma_bus_hold_arbitration_glue;
  logic        clk_sys_i, srst_i, start_i, cpu_ack_n_i, conflict_clr_i;
  logic [15:0] addr_i, data_i, mem_addr_o, mem_wdata_o, grant_count_o;
  logic [7:0]  len_i;
  logic        ready_o, data_take_o, done_o, aborted_o, cpu_req_n_o;
  logic        mem_we_o, revoke_o, conflict_o, cpu_keep, revoke_seen;
  bus_hold_pkg::owner_t owner_o;
  logic [15:0] base_addr;
  logic [1:0]  code;
  int          words, cycles, mismatches, cmp_count;

  bus_hold_if i_bus_hold_if ();
  adaptor_bus_hold i_adaptor_bus_hold (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .link(i_bus_hold_if), .start_i(start_i),
    .addr_i(addr_i), .len_i(len_i), .data_i(data_i), .ready_o(ready_o),
    .data_take_o(data_take_o), .done_o(done_o), .aborted_o(aborted_o));
  bus_hold_glue i_bus_hold_glue (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .link(i_bus_hold_if), .cpu_ack_n_i(cpu_ack_n_i),
    .conflict_clr_i(conflict_clr_i), .cpu_req_n_o(cpu_req_n_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .owner_o(owner_o), .revoke_o(revoke_o),
    .conflict_o(conflict_o), .grant_count_o(grant_count_o));
  bus_hold_chk i_bus_hold_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .hold_request_n(i_bus_hold_if.hold_request_n),
    .busy_n(i_bus_hold_if.busy_n),
    .hold_grant_n(i_bus_hold_if.hold_grant_n),
    .dma_we(i_bus_hold_if.dma_we), .dma_addr(i_bus_hold_if.dma_addr),
    .cpu_ack_n_i(cpu_ack_n_i), .cpu_req_n_o(cpu_req_n_o));

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, processor model, write monitor
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Processor hands over the bus at the falling edge after a request, half a cycle later
  always @(negedge clk_sys_i) begin
    cpu_ack_n_i <= cpu_req_n_o | cpu_keep;
    if (data_take_o) data_i <= data_i + 16'h0001;
    if (revoke_o) revoke_seen <= 1'b1;
    if (mem_we_o) begin
      check("mem_addr", mem_addr_o, base_addr + words[15:0]);
      check("mem_wdata", mem_wdata_o, 16'ha500 + words[15:0]);
      words++;
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wait_end(input int max);
    int t;
    code = 2'h0;
    for (t = 0; t < max && code == 2'h0; t++) begin
      @(negedge clk_sys_i);
      if (done_o === 1'b1) code = 2'h1;
      if (aborted_o === 1'b1) code = 2'h2;
    end
    // Last forwarded write lands with the end pulse; let it be counted
    @(negedge clk_sys_i);
  endtask

  task automatic burst(input logic [15:0] a, input logic [7:0] n,
                       input int max);
    int t;
    for (t = 0; t < 50 && ready_o !== 1'b1; t++) @(negedge clk_sys_i);
    words = 0;
    base_addr = a;
    data_i = 16'ha500;
    start_i = 1'b1;
    addr_i = a;
    len_i = n;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    wait_end(max);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {start_i, conflict_clr_i, cpu_keep, revoke_seen} = 4'h0;
    srst_i = 1'b1;
    cpu_ack_n_i = 1'b1;
    addr_i = 16'h0000;
    len_i = 8'h00;
    data_i = 16'h0000;
    repeat (10) @(negedge clk_sys_i);
    srst_i = 1'b0;
    check("owner", 16'(owner_o), 16'(bus_hold_pkg::OWNER_CPU));
    check("cpu_req", 16'(cpu_req_n_o), 16'h0001);
    burst(16'h1000, 8'h00, 8);
    check("len0_code", 16'(code), 16'h0000);
    burst(16'h1000, 8'h04, 40);
    check("code", 16'(code), 16'h0001);
    check("words", 16'(words), 16'h0004);
    burst(16'h2000, 8'hff, 400);
    check("words", 16'(words), 16'h00ff);
    check("grants", grant_count_o, 16'h0002);
    cpu_keep = 1'b1;
    burst(16'h3000, 8'h02, 20);
    check("held_code", 16'(code), 16'h0000);
    check("held_grant", 16'(i_bus_hold_if.hold_grant_n), 16'h0001);
    cpu_keep = 1'b0;
    wait_end(40);
    check("words", 16'(words), 16'h0002);
    fork
      burst(16'h4000, 8'h14, 100);
      begin
        for (int t = 0; t < 60 && words < 3; t++) @(negedge clk_sys_i);
        cpu_keep = 1'b1;
      end
    join
    check("abort_code", 16'(code), 16'h0002);
    check("abort_short", 16'(words < 20), 16'h0001);
    check("revoke", 16'(revoke_seen), 16'h0001);
    check("conflict", 16'(conflict_o), 16'h0001);
    conflict_clr_i = 1'b1;
    @(negedge clk_sys_i);
    conflict_clr_i = 1'b0;
    check("conflict_clr", 16'(conflict_o), 16'h0000);
    cpu_keep = 1'b0;
    burst(16'h5000, 8'h01, 40);
    check("restart", 16'(code), 16'h0001);
    end_of_test();
  end
endmodule
